/* rtl/fboi_pkg.sv */
// Constants, register map and types of the FSK byte output interface.
// Assumes a 10 MHz system clock and 32-bit APB register access.
package fboi_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned OSC_HZ        = 3579545;
  localparam int unsigned BIT_TIME_NS   = 833333;
  localparam int unsigned HALF_BIT_NS   = 416666;
  localparam int unsigned CD_HOLD_NS    = 10000000;
  localparam int unsigned CD_QUAL_NS    = 1000000;
  localparam int unsigned PD_SETTLE_NS  = 1000000;
  localparam int unsigned GT_CHARGE_NS  = 5000000;
  localparam int unsigned CNT_W         = 17;

  localparam logic [16:0] BIT_CYC_DEF  = 17'(BIT_TIME_NS / CLK_PERIOD_NS);
  localparam logic [16:0] HALF_CYC_DEF = 17'(HALF_BIT_NS / CLK_PERIOD_NS);
  localparam logic [16:0] CD_HOLD_DEF  = 17'(CD_HOLD_NS / CLK_PERIOD_NS);
  localparam logic [16:0] CD_QUAL_DEF  = 17'(CD_QUAL_NS / CLK_PERIOD_NS);
  localparam logic [16:0] PD_CYC_DEF   = 17'(PD_SETTLE_NS / CLK_PERIOD_NS);
  localparam logic [16:0] GT_CYC_DEF   = 17'(GT_CHARGE_NS / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Frame
  // ----------------------------------------------------------------
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [3:0] LAST_IDX  = 4'h7;

  // ----------------------------------------------------------------
  // Control select codes
  // ----------------------------------------------------------------
  localparam logic [2:0] PD_CODE   = 3'h1;
  localparam int unsigned SEL_MODE = 0;
  localparam int unsigned SEL_TONE = 2;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W     = 8;
  localparam logic [7:0]  CTRL_OFS   = 8'h00;
  localparam logic [7:0]  STATUS_OFS = 8'h04;
  localparam logic [7:0]  RXBYTE_OFS = 8'h08;
  localparam logic [2:0]  CTRL_RST   = 3'h0;

  typedef struct packed {
    logic guard_ok;
    logic power_down;
    logic tone_sel;
    logic mode1;
    logic carrier;
    logic ready_n;
  } fboi_status_t;

  typedef struct packed {
    logic data;
    logic sclk_o;
    logic sclk_oe;
    logic ready_tone;
    logic cd_n;
    logic tone_flag;
    logic gt;
  } fboi_pins_t;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP}
    fboi_rx_state_t;

endpackage

/* rtl/fboi_sync.sv */
// Two flip-flop synchroniser for pin inputs.
// Assumes inputs are asynchronous to clk; only the second stage is used.
`timescale 1ns/1ps
module fboi_sync #(
  parameter int unsigned W = 1
)(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule

/* rtl/fboi_top.sv */
// FSK byte output interface: 3-wire data link, carrier qualifier, tone
// pin sharing, power-down, APB control.
// Assumes pins are asynchronous; clk is 10 MHz; APB master on clk.
`timescale 1ns/1ps
module fboi_top #(
  parameter logic [16:0] BIT_CYC  = fboi_pkg::BIT_CYC_DEF,
  parameter logic [16:0] HALF_CYC = fboi_pkg::HALF_CYC_DEF,
  parameter logic [16:0] CD_HOLD  = fboi_pkg::CD_HOLD_DEF,
  parameter logic [16:0] CD_QUAL  = fboi_pkg::CD_QUAL_DEF,
  parameter logic [16:0] PD_CYC   = fboi_pkg::PD_CYC_DEF,
  parameter logic [16:0] GT_CYC   = fboi_pkg::GT_CYC_DEF
)(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        fsk_raw,
  input  wire logic        band_energy,
  input  wire logic        tone_raw,
  input  wire logic        shift_clock_i,
  output logic             shift_clock_o,
  output logic             shift_clock_oe,
  output logic             data_o,
  output logic             ready_or_tone_pin,
  output logic             carrier_detect_n,
  output logic             early_tone_flag,
  output logic             guard_timer_node,
  output logic             fsk_enable,
  output logic             tone_enable
);

  // ----------------------------------------------------------------
  // Reset release and input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_pipe_r;
  logic       rst_sync_n;
  logic [3:0] pins_s;
  logic       bit_s;
  logic       band_s;
  logic       tone_s;
  logic       sclk_s;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rst_pipe_r <= 2'h0;
    else
      rst_pipe_r <= {rst_pipe_r[0], 1'b1};
  end
  assign rst_sync_n = rst_pipe_r[1];

  fboi_sync #(.W(4)) u_sync (
    .clk     (clk),
    .rst_n   (rst_sync_n),
    .async_i ({shift_clock_i, tone_raw, band_energy, fsk_raw}),
    .sync_o  (pins_s)
  );
  assign bit_s  = pins_s[0];
  assign band_s = pins_s[1];
  assign tone_s = pins_s[2];
  assign sclk_s = pins_s[3];

  // ----------------------------------------------------------------
  // Control register and selections
  // ----------------------------------------------------------------
  logic [2:0]  ctrl_r;
  logic [16:0] pd_cnt_r;
  logic        pd_r;
  logic        mode1;
  logic        tone_sel;
  logic        fsk_sel;
  logic        on_code;

  assign mode1    = ctrl_r[fboi_pkg::SEL_MODE];
  assign tone_sel = ctrl_r[fboi_pkg::SEL_TONE];
  assign fsk_sel  = !tone_sel;
  assign on_code  = (ctrl_r == fboi_pkg::PD_CODE);

  // Power-down after the code has been held for PD_CYC cycles
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      pd_cnt_r <= '0;
      pd_r     <= 1'b0;
    end
    else if (!on_code)
    begin
      pd_cnt_r <= '0;
      pd_r     <= 1'b0;
    end
    else if (pd_cnt_r == PD_CYC - 17'h1)
      pd_r <= 1'b1;
    else
      pd_cnt_r <= pd_cnt_r + 17'h1;
  end

  assign fsk_enable  = !pd_r && fsk_sel;
  assign tone_enable = !pd_r && tone_sel;

  // ----------------------------------------------------------------
  // Carrier qualifier
  // ----------------------------------------------------------------
  logic [16:0] qual_cnt_r;
  logic [16:0] idle_cnt_r;
  logic        cd_active_r;
  logic        cd_allow;

  assign cd_allow = fsk_enable;

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      qual_cnt_r  <= '0;
      idle_cnt_r  <= '0;
      cd_active_r <= 1'b0;
    end
    else if (!cd_allow)
    begin
      qual_cnt_r  <= '0;
      idle_cnt_r  <= '0;
      cd_active_r <= 1'b0;
    end
    else if (!cd_active_r)
    begin
      idle_cnt_r <= '0;
      if (!band_s)
        qual_cnt_r <= '0;
      else if (qual_cnt_r == CD_QUAL - 17'h1)
        cd_active_r <= 1'b1;
      else
        qual_cnt_r <= qual_cnt_r + 17'h1;
    end
    else
    begin
      qual_cnt_r <= '0;
      if (band_s)
        idle_cnt_r <= '0;
      else if (idle_cnt_r == CD_HOLD - 17'h1)
        cd_active_r <= 1'b0;
      else
        idle_cnt_r <= idle_cnt_r + 17'h1;
    end
  end

  // ----------------------------------------------------------------
  // Bit timing recovery
  // ----------------------------------------------------------------
  fboi_pkg::fboi_rx_state_t rx_state_r;
  logic [16:0] tmr_r;
  logic [3:0]  idx_r;
  logic [7:0]  data_bits_r;
  logic        prev_bit_r;
  logic        rx_en;
  logic        at_half;
  logic        at_bit;
  logic        data_ctr;
  logic        stop_edge;
  logic        stop_ctr;

  assign rx_en     = cd_allow && cd_active_r;
  assign at_half   = (tmr_r == HALF_CYC - 17'h1);
  assign at_bit    = (tmr_r == BIT_CYC - 17'h1);
  assign data_ctr  = rx_en && (rx_state_r == fboi_pkg::RX_DATA) && at_bit;
  assign stop_edge = rx_en && (rx_state_r == fboi_pkg::RX_STOP) && at_half;
  assign stop_ctr  = rx_en && (rx_state_r == fboi_pkg::RX_STOP) && at_bit;

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      rx_state_r  <= fboi_pkg::RX_IDLE;
      tmr_r       <= '0;
      idx_r       <= '0;
      data_bits_r <= '0;
      prev_bit_r  <= 1'b1;
    end
    else if (!rx_en)
    begin
      rx_state_r <= fboi_pkg::RX_IDLE;
      tmr_r      <= '0;
      prev_bit_r <= 1'b1;
    end
    else
    begin
      prev_bit_r <= bit_s;
      tmr_r      <= (at_bit || rx_state_r == fboi_pkg::RX_IDLE) ?
                    17'h0 : tmr_r + 17'h1;
      unique case (rx_state_r)
        fboi_pkg::RX_IDLE:
          if (prev_bit_r && !bit_s)
            rx_state_r <= fboi_pkg::RX_START;
        fboi_pkg::RX_START:
          if (at_half)
          begin
            tmr_r      <= '0;
            idx_r      <= '0;
            rx_state_r <= bit_s ? fboi_pkg::RX_IDLE : fboi_pkg::RX_DATA;
          end
        fboi_pkg::RX_DATA:
          if (at_bit)
          begin
            data_bits_r[idx_r[2:0]] <= bit_s;
            idx_r <= idx_r + 4'h1;
            if (idx_r == fboi_pkg::LAST_IDX)
              rx_state_r <= fboi_pkg::RX_STOP;
          end
        fboi_pkg::RX_STOP:
          if (at_bit)
            rx_state_r <= fboi_pkg::RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Bit stream timing outputs
  // ----------------------------------------------------------------
  logic sclk0_r;
  logic ready0_r;
  logic [3:0] pulse_cnt_r;

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      sclk0_r  <= 1'b0;
      ready0_r <= 1'b1;
    end
    else if (!rx_en || mode1)
    begin
      sclk0_r  <= 1'b0;
      ready0_r <= 1'b1;
    end
    else
    begin
      if (data_ctr)
        sclk0_r <= 1'b1;
      else if (at_half)
        sclk0_r <= 1'b0;
      if (stop_edge)
        ready0_r <= 1'b0;
      else if (stop_ctr)
        ready0_r <= 1'b1;
    end
  end

  // Counts clock pulses within a frame
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      pulse_cnt_r <= '0;
    else if (rx_state_r == fboi_pkg::RX_START)
      pulse_cnt_r <= '0;
    else if (data_ctr)
      pulse_cnt_r <= pulse_cnt_r + 4'h1;
  end

  // ----------------------------------------------------------------
  // Buffer mode shift register
  // ----------------------------------------------------------------
  logic [8:0]  sreg_r;
  logic [8:0]  frame_r;
  logic        data1_r;
  logic        ready1_r;
  logic [16:0] rdy_cnt_r;
  logic        sclk_prev_r;
  logic        sclk_rise;
  logic        load1;

  assign sclk_rise = sclk_s && !sclk_prev_r;
  assign load1     = stop_ctr && mode1;

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      sreg_r      <= '1;
      frame_r     <= '0;
      data1_r     <= 1'b1;
      ready1_r    <= 1'b1;
      rdy_cnt_r   <= '0;
      sclk_prev_r <= 1'b0;
    end
    else
    begin
      sclk_prev_r <= sclk_s;
      if (stop_ctr)
        frame_r <= {bit_s, data_bits_r};
      if (load1)
      begin
        sreg_r    <= {bit_s, data_bits_r};
        ready1_r  <= 1'b0;
        rdy_cnt_r <= '0;
      end
      else
      begin
        if (sclk_rise && mode1)
        begin
          data1_r <= sreg_r[0];
          sreg_r  <= {1'b1, sreg_r[8:1]};
        end
        if (!rx_en || !mode1)
          ready1_r <= 1'b1;
        else if (!ready1_r && (sclk_rise || rdy_cnt_r == HALF_CYC - 17'h1))
          ready1_r <= 1'b1;
        if (!ready1_r)
          rdy_cnt_r <= rdy_cnt_r + 17'h1;
        else
          rdy_cnt_r <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Tone guard timer
  // ----------------------------------------------------------------
  logic [16:0] gt_cnt_r;
  logic        guard_ok_r;
  logic        tone_detect_n;

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      gt_cnt_r   <= '0;
      guard_ok_r <= 1'b0;
    end
    else if (pd_r)
      guard_ok_r <= 1'b1;
    else if (!guard_ok_r)
    begin
      if (gt_cnt_r == GT_CYC - 17'h1)
        guard_ok_r <= 1'b1;
      else
        gt_cnt_r <= gt_cnt_r + 17'h1;
    end
  end

  assign tone_detect_n = guard_ok_r ? !tone_s : 1'b0;

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  fboi_pkg::fboi_pins_t pin_r;
  fboi_pkg::fboi_pins_t pin_nxt;
  logic                 byte_ready_n;
  logic                 data_nxt;

  assign byte_ready_n = mode1 ? ready1_r : (ready0_r || !rx_en);
  assign data_nxt     = mode1 ? data1_r : (rx_en ? bit_s : 1'b1);

  always_comb
  begin
    pin_nxt.data       = pd_r ? 1'b1 : data_nxt;
    pin_nxt.sclk_o     = sclk0_r || !rx_en;
    pin_nxt.sclk_oe    = !pd_r && !mode1;
    pin_nxt.ready_tone = pd_r ? 1'b1 :
                         (tone_sel ? tone_detect_n : byte_ready_n);
    pin_nxt.cd_n       = pd_r || !cd_active_r;
    pin_nxt.tone_flag  = tone_enable && tone_s;
    pin_nxt.gt         = !pd_r && (!guard_ok_r || (tone_sel && tone_s));
  end

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      pin_r <= '{data: 1'b1, sclk_o: 1'b1, sclk_oe: 1'b1,
                 ready_tone: 1'b0, cd_n: 1'b1, tone_flag: 1'b0, gt: 1'b1};
    else
      pin_r <= pin_nxt;
  end

  assign data_o            = pin_r.data;
  assign shift_clock_o     = pin_r.sclk_o;
  assign shift_clock_oe    = pin_r.sclk_oe;
  assign ready_or_tone_pin = pin_r.ready_tone;
  assign carrier_detect_n  = pin_r.cd_n;
  assign early_tone_flag   = pin_r.tone_flag;
  assign guard_timer_node  = pin_r.gt;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  fboi_pkg::fboi_status_t status;
  logic        hit_ctrl;
  logic        hit_stat;
  logic        hit_rx;
  logic        hit;
  logic        setup;
  logic        wr_ctrl;
  logic [31:0] rd_mux;

  assign hit_ctrl = (paddr == fboi_pkg::CTRL_OFS);
  assign hit_stat = (paddr == fboi_pkg::STATUS_OFS);
  assign hit_rx   = (paddr == fboi_pkg::RXBYTE_OFS);
  assign hit      = hit_ctrl || hit_stat || hit_rx;
  assign setup    = psel && !penable;
  assign wr_ctrl  = psel && penable && pwrite && hit_ctrl;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !hit;

  assign status = '{guard_ok: guard_ok_r, power_down: pd_r,
                    tone_sel: tone_sel, mode1: mode1,
                    carrier: cd_active_r, ready_n: byte_ready_n};
  assign rd_mux = hit_ctrl ? {29'h0, ctrl_r} :
                  hit_stat ? {26'h0, status} :
                  hit_rx   ? {23'h0, frame_r} : 32'h0;

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      ctrl_r <= fboi_pkg::CTRL_RST;
      prdata <= '0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= pwdata[2:0];
      if (setup && !pwrite)
        prdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb_main @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  sequence s_data_centre;
    data_ctr && !mode1;
  endsequence

  sequence s_stop_centre;
    stop_ctr;
  endsequence

  AST_CLOCK_CENTRE: assert property (s_data_centre |=> sclk0_r)
    else $error("shift clock did not rise at bit centre");

  AST_EIGHT_PULSES: assert property (
    s_stop_centre |-> pulse_cnt_r == fboi_pkg::DATA_BITS)
    else $error("frame did not carry eight shift clocks");

  AST_READY0_STOP: assert property (
    $fell(ready0_r) |-> $past(rx_state_r) == fboi_pkg::RX_STOP)
    else $error("bit stream ready fell outside stop bit");

  AST_BUFFER_LOAD: assert property (
    (s_stop_centre and mode1) |=>
      !ready1_r && sreg_r == {$past(bit_s), $past(data_bits_r)})
    else $error("buffer load or ready strobe missing");

  AST_EARLY_RELEASE: assert property (
    (mode1 && !ready1_r && sclk_rise && !load1) |=> ready1_r)
    else $error("first host clock did not release ready");

  AST_READY_WIDTH: assert property (rdy_cnt_r <= HALF_CYC)
    else $error("buffer ready held past half a bit");

  AST_CD_QUAL: assert property (
    $rose(cd_active_r) |-> $past(qual_cnt_r) == CD_QUAL - 17'h1)
    else $error("carrier asserted without qualification");

  AST_CD_HOLD: assert property (
    $fell(cd_active_r) |->
      ($past(idle_cnt_r) == CD_HOLD - 17'h1) || !$past(cd_allow))
    else $error("carrier released before hold time");

  AST_NO_CARRIER_PINS: assert property (
    (!rx_en && !mode1 && fsk_sel && !pd_r) |=>
      data_o && shift_clock_o && ready_or_tone_pin)
    else $error("bit stream pins not high without carrier");

  AST_SHARED_PIN: assert property (
    (tone_sel && !pd_r) |=> ready_or_tone_pin == $past(tone_detect_n))
    else $error("shared pin does not follow tone detect");

  AST_PD_SETTLE: assert property (
    $rose(pd_r) |-> $past(pd_cnt_r) == PD_CYC - 17'h1 && $past(on_code))
    else $error("power-down entered without settled code");

  AST_PD_PINS: assert property (
    pd_r |=> data_o && ready_or_tone_pin && carrier_detect_n &&
             !early_tone_flag && !guard_timer_node && !shift_clock_oe)
    else $error("power-down pin levels wrong");

endmodule

/* verification/fboi_host_model.sv */
// Host model: polls the link in bit-stream mode, clocks the buffer out.
// Assumes pin is the resolved shift clock level, sampled on clk.
`timescale 1ns/1ps
module fboi_host_model (
  input  wire logic clk,
  input  wire logic pin,
  input  wire logic data,
  input  wire logic ready,
  output logic      sclk
);
  logic       prev;
  logic       rdy0;
  logic [7:0] cap;
  int         ncap;
  int         n_ferr;

  initial
  begin
    sclk = 1'b0;
    prev = 1'b0;
    ncap = 0;
    n_ferr = 0;
  end

  // Keep the last eight bits seen at clock rises
  always @(posedge clk)
  begin
    prev <= pin;
    if (pin && !prev)
    begin
      cap  <= {data, cap[7:1]};
      ncap <= ncap + 1;
    end
  end

  // n pulses, hi cycles per phase; bit taken before the next rise
  task automatic read_buf(input int n, input int hi, output logic [8:0] v);
    v = 9'h000;
    @(posedge clk);
    for (int i = 0; i < n; i++)
    begin
      sclk <= 1'b1;
      repeat (hi) @(posedge clk);
      sclk <= 1'b0;
      repeat (hi) @(posedge clk);
      v[i] = data;
      if (i == 0)
        rdy0 = ready;
    end
    if (n == 9 && !v[8])
      n_ferr++;
  endtask
endmodule

/* verification/testbench.sv */
// Self-checking bench: APB calls, serial frames and host reads.
// Assumes short timing parameters: 40 clocks a bit, 20 a half bit.
`timescale 1ns/1ps
module testbench;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        fsk_raw, band_energy, tone_raw, r1, r2;
  logic        sclk_o, sclk_oe, host_sclk, pin, data_o, rdy, cd_n;
  logic        etf, gt, fsk_en, tone_en;
  logic [8:0]  v;
  int          n_fail = 0, n_tests = 0, cyc = 0, n0;

  // Host model clock drives the pin whenever the device is not driving
  assign pin = sclk_oe ? sclk_o : host_sclk;

  fboi_top #(.BIT_CYC(17'h28), .HALF_CYC(17'h14), .CD_HOLD(17'hc8),
    .CD_QUAL(17'ha), .PD_CYC(17'h5)) fboi_top_inst (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fsk_raw(fsk_raw),
    .band_energy(band_energy), .tone_raw(tone_raw),
    .shift_clock_i(pin), .shift_clock_o(sclk_o),
    .shift_clock_oe(sclk_oe), .data_o(data_o), .ready_or_tone_pin(rdy),
    .carrier_detect_n(cd_n), .early_tone_flag(etf),
    .guard_timer_node(gt), .fsk_enable(fsk_en), .tone_enable(tone_en));

  fboi_host_model fboi_host_model_inst (.clk(clk), .pin(pin),
    .data(data_o), .ready(rdy), .sclk(host_sclk));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 10000)
    begin
      n_fail++;
      print_verdict;
    end
  end

  task automatic print_verdict;
    $display("Comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // Start, eight bits LSB first, stop; returns 30 cycles into stop
  task automatic send(input logic [7:0] b, input logic stop);
    fsk_raw <= 1'b0;
    repeat (40) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      fsk_raw <= b[i];
      repeat (40) @(posedge clk);
    end
    fsk_raw <= stop;
    repeat (10) @(posedge clk);
    r1 = rdy;
    repeat (20) @(posedge clk);
    r2 = rdy;
  endtask

  initial
  begin
    rst_n = 1'b0;
    {psel, penable, pwrite, fsk_raw, band_energy, tone_raw} = 6'h04;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h0c, 32'h0);
    chk({err, rd[30:0]}, {1'b1, 31'h0});
    chk({data_o, sclk_o, rdy, fsk_en, tone_en}, 5'h1e);
    band_energy <= 1'b1;
    repeat (30) @(posedge clk);
    chk(cd_n, 1'b0);
    n0 = fboi_host_model_inst.ncap;
    send(8'ha5, 1'b1);
    chk({r1, r2}, 2'h1);
    chk(fboi_host_model_inst.ncap - n0, 8);
    chk(fboi_host_model_inst.cap, 8'ha5);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h1a5);
    apb(1'b1, 8'h00, 32'h3);
    @(posedge clk);
    chk(sclk_oe, 1'b0);
    send(8'h96, 1'b1);
    chk(r2, 1'b0);
    fboi_host_model_inst.read_buf(9, 4, v);
    chk(v, 9'h196);
    chk(fboi_host_model_inst.rdy0, 1'b1);
    send(8'h5a, 1'b0);
    chk(r2, 1'b0);
    fsk_raw <= 1'b1;
    repeat (30) @(posedge clk);
    chk(rdy, 1'b1);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h05a);
    fboi_host_model_inst.read_buf(9, 4, v);
    chk(v, 9'h05a);
    chk(fboi_host_model_inst.n_ferr, 1);
    band_energy <= 1'b0;
    repeat (100) @(posedge clk);
    chk(cd_n, 1'b0);
    repeat (150) @(posedge clk);
    chk(cd_n, 1'b1);
    send(8'h11, 1'b1);
    chk({r1, r2}, 2'h3);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h05a);
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b1, 8'h00, 32'h3);
    repeat (10) @(posedge clk);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd[4], 1'b0);
    apb(1'b1, 8'h00, 32'h1);
    repeat (20) @(posedge clk);
    chk({data_o, rdy, cd_n, etf, gt, sclk_oe}, 6'h38);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd[4], 1'b1);
    apb(1'b1, 8'h00, 32'h4);
    repeat (5) @(posedge clk);
    chk({fsk_en, tone_en}, 2'h1);
    tone_raw <= 1'b1;
    repeat (10) @(posedge clk);
    chk(rdy, 1'b0);
    chk(etf, 1'b1);
    tone_raw <= 1'b0;
    repeat (10) @(posedge clk);
    chk(rdy, 1'b1);
    print_verdict;
  end
endmodule
